/* hdl/src_pin_sync.sv */
// Three-flop input synchronizer with agreement filter
`timescale 1ns/1ps
module src_pin_sync #(
	parameter int unsigned     WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Raw input and filtered level
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);
	import src_pkg::*;

	logic [WIDTH-1:0] ff1_r;
	logic [WIDTH-1:0] ff2_r;
	logic [WIDTH-1:0] ff3_r;

	// Chain, first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff1_r <= RST_VAL;
			ff2_r <= RST_VAL;
			ff3_r <= RST_VAL;
		end else begin
			ff1_r <= pinIn;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
		end
	end

	// Per bit, a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					pinOut[gi] <= RST_VAL[gi];
				end else if (ff2_r[gi] == ff3_r[gi]) begin
					pinOut[gi] <= ff3_r[gi];
				end
			end
		end
	endgenerate

endmodule

/* hdl/src_reset_ctrl.sv */
// Subsystem reset controller top
//
// Overview of operation
// - Power-on reset clears everything except the debug port.
// - Debug pad resets only debug port and TAP, not warm set.
// - Soft-reset bit set holds peripheral in reset, clock gated off.
// - Processor reset request follows its system-reset-request control bit.
// - External pad is both reset input and processor-controlled reset output.
// - Both brownout lines become interrupt sources and readable status bits.
// - Processor power-on reset is a synchronized copy of supply power-on reset.
// - System reset drives processor system reset and resets whole subsystem.
// - System reset leaves processor debug logic untouched.
// - System reset asserts asynchronously, releases synchronously to main clock.
// - Fabric request counts toward system reset only when enabled.
// - Debug reset output resets only the debug port sub-block.
// - Fabric reset asserts asynchronously, releases synchronously to main clock.
// - Fabric reset uses system sources but never the fabric request.
// - Watchdog-domain reset releases synchronously to the RC oscillator clock.
// - Pad driven low from power-on until firmware clears its soft-reset bit.
`timescale 1ns/1ps
module src_reset_ctrl (
	// Main clock and controller reset
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	// RC oscillator clock of the watchdog
	input  wire logic                                rc_oscillator_clock,
	// Supply monitor and debug pad
	input  wire src_pkg::src_supply_t                supply,
	input  wire logic                                debugPadResetN,
	// Warm reset sources
	input  wire src_pkg::src_sources_t               sources,
	// External reset pad, two-way
	input  wire logic                                extResetPadInN,
	output logic                                     extResetPadOut,
	output logic                                     extResetPadDriveN,
	// Reset outputs
	output logic                                     cpuPowerOnResetN,
	output logic                                     systemResetN,
	output logic                                     debugPortResetN,
	output logic                                     resetToFabricN,
	output logic                                     watchdogDomainResetN,
	// Peripheral resets and clock enables
	output logic [src_pkg::SRC_NUM_PERIPH-1:0]       periphResetN,
	output logic [src_pkg::SRC_NUM_PERIPH-1:0]       periphClkEn,
	// Brownout interrupt sources
	output logic                                     highBrownoutIrq,
	output logic                                     coreBrownoutIrq,
	// Register port
	input  wire src_pkg::src_reg_req_t               regReq,
	output logic [31:0]                              regRdData
);
	import src_pkg::*;

	// Power-on clear, combined controller and supply reset
	logic porClrN;
	assign porClrN = rst_n & supply.powerOnResetN;

	// Synchronized outside-domain inputs
	logic wdogSync;
	logic fabReqNSync;
	logic padInNSync;
	logic highBoSync;
	logic coreBoSync;

	src_pin_sync #(
		.WIDTH   (5),
		.RST_VAL (5'b0_1100)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.rst_n   (porClrN),
		.pinIn   ({sources.watchdogExpired, sources.fabricResetRequestN,
		            extResetPadInN, supply.highSupplyBrownout,
		            supply.coreSupplyBrownout}),
		.pinOut  ({wdogSync, fabReqNSync, padInNSync, highBoSync, coreBoSync})
	);

	// Software control bits
	logic [SRC_NUM_PERIPH-1:0] periphSoftRst_r;
	logic                      extPadSoftRst_r;
	logic                      fabricResetEnable_r;

	// Processor sources sampled once on the main clock
	logic cpuReqS_r;
	logic cpuLockS_r;

	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			cpuReqS_r  <= 1'b0;
			cpuLockS_r <= 1'b0;
		end else begin
			cpuReqS_r  <= sources.cpuResetRequest;
			cpuLockS_r <= sources.cpuLockup;
		end
	end

	// Pad window state and drive
	src_pad_state_t padState_r;
	src_pad_state_t padState_nxt;
	logic           padDrive_r;
	logic           padDrive_nxt;

	// Source terms
	logic fabReqGated;
	logic coreSrc;
	logic padReset;
	logic sysHold_nxt;
	logic fabHold_nxt;
	logic rcHold_nxt;

	// Pad low only counts in the armed window while not self-driven
	assign fabReqGated = ~fabReqNSync & fabricResetEnable_r;
	assign coreSrc     = cpuReqS_r | cpuLockS_r | wdogSync;
	assign padReset    = (padState_r == SRC_PAD_ARMED) & ~padInNSync
	                     & ~padDrive_r;

	// Per-output hold terms
	always_comb begin
		sysHold_nxt = coreSrc | fabReqGated | padReset;
		fabHold_nxt = coreSrc | padReset;
		rcHold_nxt  = cpuReqS_r | cpuLockS_r | fabReqGated | padReset;
	end

	// Hold flops keep asynchronous clears glitch free
	logic sysHold_r;
	logic fabHold_r;
	logic rcHold_r;

	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			sysHold_r <= 1'b0;
			fabHold_r <= 1'b0;
			rcHold_r  <= 1'b0;
		end else begin
			sysHold_r <= sysHold_nxt;
			fabHold_r <= fabHold_nxt;
			rcHold_r  <= rcHold_nxt;
		end
	end

	// Pad state machine
	always_comb begin
		padState_nxt = padState_r;
		unique case (padState_r)
			SRC_PAD_DRIVE: begin
				if (!extPadSoftRst_r) begin
					padState_nxt = SRC_PAD_SETTLE;
				end
			end
			SRC_PAD_SETTLE: begin
				if (!coreSrc && !fabReqGated && padInNSync) begin
					padState_nxt = SRC_PAD_ARMED;
				end
			end
			SRC_PAD_ARMED: begin
				if (coreSrc || fabReqGated) begin
					padState_nxt = SRC_PAD_SETTLE;
				end
			end
			default: begin
				padState_nxt = SRC_PAD_DRIVE;
			end
		endcase
	end

	// Pad driven in power-on phase, then on any internal source
	always_comb begin
		padDrive_nxt = (padState_nxt == SRC_PAD_DRIVE)
		               | ((padState_nxt != SRC_PAD_DRIVE)
		                  & (coreSrc | fabReqGated));
	end

	// Pad state register, entered in drive on power-on
	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			padState_r <= SRC_PAD_DRIVE;
			padDrive_r <= 1'b1;
		end else begin
			padState_r <= padState_nxt;
			padDrive_r <= padDrive_nxt;
		end
	end

	// Pad pins, low level with active-low enable
	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			extResetPadOut    <= 1'b0;
			extResetPadDriveN <= 1'b0;
		end else begin
			extResetPadOut    <= 1'b0;
			extResetPadDriveN <= ~padDrive_nxt;
		end
	end

	// Synchronizer clears
	logic sysClrN;
	logic fabClrN;
	logic rcClrN;

	assign sysClrN = porClrN & ~sysHold_r;
	assign fabClrN = porClrN & ~fabHold_r;
	assign rcClrN  = porClrN & ~rcHold_r;

	// Processor power-on reset, power-on clear only
	src_reset_sync u_cpu_por (
		.clk    (sys_clk),
		.clrN   (porClrN),
		.resetN (cpuPowerOnResetN)
	);

	// Subsystem system reset, debug logic not on this net
	src_reset_sync u_sys_rst (
		.clk    (sys_clk),
		.clrN   (sysClrN),
		.resetN (systemResetN)
	);

	// Fabric reset
	src_reset_sync u_fab_rst (
		.clk    (sys_clk),
		.clrN   (fabClrN),
		.resetN (resetToFabricN)
	);

	// Watchdog domain reset on the oscillator clock
	src_reset_sync u_rc_rst (
		.clk    (rc_oscillator_clock),
		.clrN   (rcClrN),
		.resetN (watchdogDomainResetN)
	);

	// Debug port reset from the debug pad alone
	src_reset_sync u_dbg_rst (
		.clk    (sys_clk),
		.clrN   (debugPadResetN),
		.resetN (debugPortResetN)
	);

	// Per-peripheral reset and clock enable
	genvar gp;
	generate
		for (gp = 0; gp < SRC_NUM_PERIPH; gp++) begin : g_periph
			always_ff @(posedge sys_clk or negedge sysClrN) begin
				if (!sysClrN) begin
					periphResetN[gp] <= 1'b0;
					periphClkEn[gp]  <= 1'b0;
				end else begin
					periphResetN[gp] <= ~periphSoftRst_r[gp];
					periphClkEn[gp]  <= ~periphSoftRst_r[gp];
				end
			end
		end
	endgenerate

	// Brownout interrupt source levels
	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			highBrownoutIrq <= 1'b0;
			coreBrownoutIrq <= 1'b0;
		end else begin
			highBrownoutIrq <= highBoSync;
			coreBrownoutIrq <= coreBoSync;
		end
	end

	// Soft-reset control register, kept across warm resets
	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			periphSoftRst_r     <= SRC_SOFT_RST_RESET[SRC_PERIPH_SR_LSB +: SRC_NUM_PERIPH];
			extPadSoftRst_r     <= SRC_SOFT_RST_RESET[SRC_EXT_PAD_SOFT_RESET_BIT_BIT];
			fabricResetEnable_r <= SRC_SOFT_RST_RESET[SRC_FAB_EN_BIT];
		end else if (regReq.wr && regReq.addr == SRC_SOFT_RST_CTRL_OFF) begin
			periphSoftRst_r     <= regReq.wrData[SRC_PERIPH_SR_LSB +: SRC_NUM_PERIPH];
			extPadSoftRst_r     <= regReq.wrData[SRC_EXT_PAD_SOFT_RESET_BIT_BIT];
			fabricResetEnable_r <= regReq.wrData[SRC_FAB_EN_BIT];
		end
	end

	// Read multiplexer
	logic [31:0] rdMux;

	always_comb begin
		rdMux = SRC_RD_IDLE;
		if (regReq.addr == SRC_SYS_STATUS_OFF) begin
			rdMux[SRC_SR_HIGH_BO_BIT]                 = highBoSync;
			rdMux[SRC_SR_CORE_BO_BIT]                 = coreBoSync;
			rdMux[SRC_SR_PAD_STATE_LSB +: 2]          = padState_r;
			rdMux[SRC_SR_SYS_HOLD_BIT]                = sysHold_r;
			rdMux[SRC_SR_FAB_HOLD_BIT]                = fabHold_r;
			rdMux[SRC_SR_PAD_DRIVE_BIT]               = padDrive_r;
		end else if (regReq.addr == SRC_SOFT_RST_CTRL_OFF) begin
			rdMux[SRC_PERIPH_SR_LSB +: SRC_NUM_PERIPH] = periphSoftRst_r;
			rdMux[SRC_EXT_PAD_SOFT_RESET_BIT_BIT]                      = extPadSoftRst_r;
			rdMux[SRC_FAB_EN_BIT]                      = fabricResetEnable_r;
		end
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge sys_clk or negedge porClrN) begin
		if (!porClrN) begin
			regRdData <= SRC_RD_IDLE;
		end else if (regReq.rd) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= SRC_RD_IDLE;
		end
	end

endmodule

/* hdl/src_reset_sync.sv */
// Reset synchronizer: asynchronous assert, two-flop synchronous release
`timescale 1ns/1ps
module src_reset_sync (
	// Destination clock and combined clear
	input  wire logic clk,
	input  wire logic clrN,
	// Synchronized reset, active low
	output logic      resetN
);
	import src_pkg::*;

	logic stage1_r;

	// Clear wins at once, release takes two edges
	always_ff @(posedge clk or negedge clrN) begin
		if (!clrN) begin
			stage1_r <= 1'b0;
			resetN   <= 1'b0;
		end else begin
			stage1_r <= 1'b1;
			resetN   <= stage1_r;
		end
	end

endmodule

/* include/src_pkg.sv */
// Shared constants and carrier types for the subsystem reset controller
package src_pkg;

	// Register byte addresses
	localparam logic [31:0] SRC_SYS_STATUS_OFF    = 32'hE004_201C;
	localparam logic [31:0] SRC_SOFT_RST_CTRL_OFF = 32'hE004_2030;

	// Peripheral soft-reset lanes
	localparam int unsigned SRC_NUM_PERIPH = 8;

	// Soft-reset control field positions
	localparam int unsigned SRC_PERIPH_SR_LSB = 0;
	localparam int unsigned SRC_EXT_PAD_SOFT_RESET_BIT_BIT    = 8;
	localparam int unsigned SRC_FAB_EN_BIT    = 9;
	localparam int unsigned SRC_CTRL_MSB      = 9;
	localparam logic [31:0] SRC_SOFT_RST_RESET = 32'h0000_0100;

	// System status field positions
	localparam int unsigned SRC_SR_HIGH_BO_BIT   = 0;
	localparam int unsigned SRC_SR_CORE_BO_BIT   = 1;
	localparam int unsigned SRC_SR_PAD_STATE_LSB = 2;
	localparam int unsigned SRC_SR_SYS_HOLD_BIT  = 4;
	localparam int unsigned SRC_SR_FAB_HOLD_BIT  = 5;
	localparam int unsigned SRC_SR_PAD_DRIVE_BIT = 6;

	// Read data answer when nothing is read
	localparam logic [31:0] SRC_RD_IDLE = 32'h0000_0000;

	// External reset pad window states, Gray along the path
	typedef enum logic [1:0] {
		SRC_PAD_DRIVE  = 2'b00,
		SRC_PAD_SETTLE = 2'b01,
		SRC_PAD_ARMED  = 2'b11
	} src_pad_state_t;

	// Register port request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wrData;
		logic        wr;
		logic        rd;
	} src_reg_req_t;

	// Warm reset sources from the processor, watchdog and fabric
	typedef struct packed {
		logic cpuResetRequest;
		logic cpuLockup;
		logic watchdogExpired;
		logic fabricResetRequestN;
	} src_sources_t;

	// Supply monitor inputs
	typedef struct packed {
		logic powerOnResetN;
		logic highSupplyBrownout;
		logic coreSupplyBrownout;
	} src_supply_t;

endpackage

/* tb/src_partner_model.sv */
// Behavioural processor core, fabric master and supply monitor
`timescale 1ns/1ps
module src_partner_model
	import src_pkg::*;
(
	// Main clock and system reset seen by the core
	input  wire logic             sys_clk,
	input  wire logic             systemResetN,
	// Lines toward the controller
	output src_pkg::src_supply_t  supply,
	output src_pkg::src_sources_t sources
);
	// Lines: 0 por, 1 request bit, 2 cpu_a, 3 watchdog, 4 fabric, 5 high bo, 6 core bo
	logic [6:0] lv = 7'h10;

	// The core drops its request bit once system reset takes hold
	always @(posedge sys_clk) begin
		if (!systemResetN)
			lv[1] <= 1'b0;
	end

	// Carrier assembly
	assign supply  = '{lv[0], lv[5], lv[6]};
	assign sources = '{lv[1], lv[2], lv[3], lv[4]};

	// Move one line just after the next rising edge
	task automatic drive(input int unsigned which, input logic val);
		@(posedge sys_clk);
		lv[which] <= val;
	endtask
endmodule

/* tb/src_reset_ctrl_assertions.sv */
// Concurrent checks on the reset controller ports
`timescale 1ns/1ps
module src_reset_ctrl_checker
	import src_pkg::*;
(
	// Clock and controller reset
	input wire logic                                sys_clk,
	input wire logic                                rst_n,
	// Sources
	input wire src_pkg::src_supply_t                supply,
	input wire logic                                debugPadResetN,
	input wire src_pkg::src_sources_t               sources,
	// Observed outputs
	input wire logic                                extResetPadOut,
	input wire logic                                extResetPadDriveN,
	input wire logic                                cpuPowerOnResetN,
	input wire logic                                systemResetN,
	input wire logic                                debugPortResetN,
	input wire logic                                resetToFabricN,
	input wire logic [src_pkg::SRC_NUM_PERIPH-1:0]  periphResetN,
	input wire logic [src_pkg::SRC_NUM_PERIPH-1:0]  periphClkEn,
	input wire logic                                highBrownoutIrq,
	input wire logic                                coreBrownoutIrq
);
	// All checks on the main clock
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	chk_por_clears: assert property (
		!supply.powerOnResetN |-> !cpuPowerOnResetN && !systemResetN && !resetToFabricN
			&& !extResetPadDriveN) else $error("outputs free during power-on reset");
	chk_por_sync: assert property (
		$rose(cpuPowerOnResetN) |-> $past(supply.powerOnResetN, 2))
		else $error("power-on release not two edges late");
	chk_lock_sys: assert property (
		sources.cpuLockup |-> ##[1:3] !systemResetN) else $error("cpu_a gave no reset");
	chk_req_hold: assert property (
		$rose(sources.cpuResetRequest) |-> ##[1:3] !systemResetN [*2])
		else $error("request reset too short");
	chk_lock_fab: assert property (
		sources.cpuLockup |-> ##[1:3] !resetToFabricN) else $error("cpu_a gave no fabric reset");
	chk_fab_subset: assert property (
		!resetToFabricN |-> !systemResetN) else $error("fabric reset without system reset");
	chk_debug_kept: assert property (
		debugPadResetN && $past(debugPadResetN) && $past(debugPortResetN) |-> debugPortResetN)
		else $error("debug port reset without its pad");
	chk_debug_reset: assert property (
		!debugPadResetN |-> !debugPortResetN) else $error("debug pad ignored");
	chk_gate_pair: assert property (
		periphClkEn == periphResetN) else $error("clock enable not tied to reset");
	chk_pad_value: assert property (
		extResetPadOut == 1'b0) else $error("pad drive value not low");
	chk_bo_irq: assert property (
		supply.highSupplyBrownout && supply.coreSupplyBrownout
			|-> ##[1:6] highBrownoutIrq && coreBrownoutIrq) else $error("brownout irq missing");

	// Main scenarios reached
	cover property (sources.cpuLockup);
	cover property ($fell(debugPadResetN));
	cover property (!extResetPadDriveN && cpuPowerOnResetN);
endmodule

bind src_reset_ctrl src_reset_ctrl_checker i_src_reset_ctrl_checker (.sys_clk, .rst_n,
	.supply, .debugPadResetN, .sources, .extResetPadOut, .extResetPadDriveN,
	.cpuPowerOnResetN, .systemResetN, .debugPortResetN, .resetToFabricN, .periphResetN,
	.periphClkEn, .highBrownoutIrq, .coreBrownoutIrq);

/* tb/tb_src_reset_ctrl.sv */
// Self-checking bench for the subsystem reset controller
`timescale 1ns/1ps
module tb_src_reset_ctrl;
	import src_pkg::*;
	// One warm source case: line, fabric enable, reset and fabric reset expected
	typedef struct {
		int unsigned which;
		logic        fabEn;
		logic        expSys;
		logic        expFab;
	} src_row_t;

	src_row_t                  rows [5];
	logic                      sys_clk        = 1'b0;
	logic                      rc_oscillator_clock       = 1'b0;
	logic                      rst_n          = 1'b0;
	logic                      debugPadResetN = 1'b0;
	logic                      extLow         = 1'b0;
	src_reg_req_t              regReq         = '0;
	src_supply_t               supply;
	src_sources_t              sources;
	logic                      extResetPadInN, extResetPadOut, extResetPadDriveN;
	logic                      cpuPowerOnResetN, systemResetN, debugPortResetN;
	logic                      resetToFabricN, watchdogDomainResetN;
	logic                      highBrownoutIrq, coreBrownoutIrq;
	logic [SRC_NUM_PERIPH-1:0] periphResetN, periphClkEn;
	logic [31:0]               regRdData;
	logic                      sawSys, sawFab, sawPad;
	int                        numErrors = 0;
	int                        totalChecks = 0;
	int                        cycles = 0;

	// Clocks; the oscillator is unrelated in phase
	always #12.5 sys_clk = ~sys_clk;
	always #15.7 rc_oscillator_clock = ~rc_oscillator_clock;

	// Open-drain pad with pull-up, pulled low by device or outside
	assign extResetPadInN = (extResetPadDriveN | extResetPadOut) & ~extLow;

	src_reset_ctrl i_src_reset_ctrl (.sys_clk, .rst_n, .rc_oscillator_clock, .supply, .debugPadResetN,
		.sources, .extResetPadInN, .extResetPadOut, .extResetPadDriveN, .cpuPowerOnResetN,
		.systemResetN, .debugPortResetN, .resetToFabricN, .watchdogDomainResetN,
		.periphResetN, .periphClkEn, .highBrownoutIrq, .coreBrownoutIrq, .regReq, .regRdData);
	src_partner_model i_src_partner_model (.sys_clk, .systemResetN, .supply, .sources);

	// Compare and count
	task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Bus write cycle
	task automatic regWrite(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regReq <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		regReq.wr <= 1'b0;
	endtask

	// Bus read cycle, data taken in the cycle after the strobe
	task automatic readCheck(input logic [31:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		regReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge sys_clk);
		regReq.rd <= 1'b0;
		#1 cmpVal(regRdData, exp);
	endtask

	// Watch reset outputs and pad drive over a window
	task automatic watch(input int unsigned n);
		sawSys = 1'b0;
		sawFab = 1'b0;
		sawPad = 1'b0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			sawSys |= !systemResetN;
			sawFab |= !resetToFabricN;
			sawPad |= !extResetPadDriveN;
		end
	endtask

	// Verdict and end of run
	task automatic endOfTest();
		$display("checks %0d errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 4000) begin
			numErrors++;
			endOfTest();
		end
	end

	// Main sequence
	initial begin
		rows = '{'{1, 1'b0, 1'b1, 1'b1}, '{2, 1'b0, 1'b1, 1'b1}, '{3, 1'b0, 1'b1, 1'b1},
			'{4, 1'b1, 1'b1, 1'b0}, '{4, 1'b0, 1'b0, 1'b0}};
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		debugPadResetN <= 1'b1;
		i_src_partner_model.drive(0, 1'b1);
		watch(4);
		cmpVal(cpuPowerOnResetN, 1'b1);
		cmpVal(watchdogDomainResetN, 1'b1);
		cmpVal(sawPad, 1'b1);
		readCheck(SRC_SOFT_RST_CTRL_OFF, SRC_SOFT_RST_RESET);
		regWrite(SRC_SYS_STATUS_OFF, 32'hFFFF_FFFF);
		readCheck(SRC_SYS_STATUS_OFF, 32'h0000_0040);
		readCheck(32'hE004_2040, SRC_RD_IDLE);
		regWrite(SRC_SOFT_RST_CTRL_OFF, 32'h0000_00A5);
		watch(8);
		cmpVal(periphResetN, 8'h5A);
		cmpVal(periphClkEn, 8'h5A);
		cmpVal(extResetPadDriveN, 1'b1);
		foreach (rows[i]) begin
			regWrite(SRC_SOFT_RST_CTRL_OFF, {22'h00_0000, rows[i].fabEn, 9'h000});
			i_src_partner_model.drive(rows[i].which, rows[i].which != 4);
			watch(10);
			cmpVal(sawSys, rows[i].expSys);
			cmpVal(sawFab, rows[i].expFab);
			cmpVal(sawPad, rows[i].expSys);
			i_src_partner_model.drive(rows[i].which, rows[i].which == 4);
			watch(12);
			cmpVal(systemResetN, 1'b1);
		end
		// Outside party pulls the pad
		@(posedge sys_clk) extLow <= 1'b1;
		watch(10);
		cmpVal(sawSys, 1'b1);
		cmpVal(sawFab, 1'b1);
		@(posedge sys_clk) extLow <= 1'b0;
		watch(12);
		// Debug pad touches only the debug port
		@(posedge sys_clk) debugPadResetN <= 1'b0;
		watch(4);
		cmpVal(debugPortResetN, 1'b0);
		cmpVal(sawSys, 1'b0);
		@(posedge sys_clk) debugPadResetN <= 1'b1;
		watch(4);
		cmpVal(debugPortResetN, 1'b1);
		// Brownouts as irq lines and status
		i_src_partner_model.drive(5, 1'b1);
		i_src_partner_model.drive(6, 1'b1);
		watch(8);
		cmpVal({highBrownoutIrq, coreBrownoutIrq}, 2'b11);
		readCheck(SRC_SYS_STATUS_OFF, 32'h0000_000F);
		i_src_partner_model.drive(5, 1'b0);
		i_src_partner_model.drive(6, 1'b0);
		// Power-on reset in mid-run
		regWrite(SRC_SOFT_RST_CTRL_OFF, 32'h0000_0003);
		i_src_partner_model.drive(0, 1'b0);
		watch(3);
		cmpVal({cpuPowerOnResetN, watchdogDomainResetN, periphResetN}, 10'h000);
		cmpVal(debugPortResetN, 1'b1);
		i_src_partner_model.drive(0, 1'b1);
		watch(4);
		cmpVal(sawPad, 1'b1);
		// Pad pulled outside its window is refused
		@(posedge sys_clk) extLow <= 1'b1;
		watch(8);
		cmpVal(sawSys, 1'b0);
		@(posedge sys_clk) extLow <= 1'b0;
		readCheck(SRC_SOFT_RST_CTRL_OFF, SRC_SOFT_RST_RESET);
		endOfTest();
	end
endmodule
